// File: tsc_pkg.sv
// How it works
// R1: Run flag 0 stops, 1 lets timer count
// R2: Eight independent run flags, A0-A4, B0-B2
// R3: Run flags clear to zero on reset
// R4: Writing 1 starts that A timer's one-shot
// R5: One-shot start flags always read as 0
// R6: One-shot start register clears on reset
// R7: One-shot needs mode, source 0, run first
// R8: One-shot flags sit in bits 4 to 0
// R9: Cleared run flag freezes the counter value
package tsc_pkg;

  localparam int          ADDR_W            = 12;
  localparam int          DATA_W            = 32;
  localparam int          NUM_TIMERS        = 8;
  localparam int          NUM_A_TIMERS      = 5;

  // Register indices; the byte address is four times the index
  localparam logic [9:0]  COUNT_START_IDX   = 10'h320;
  localparam logic [9:0]  ONE_SHOT_IDX      = 10'h322;
  localparam logic [9:0]  TIMER_CFG_IDX     = 10'h330;
  localparam logic [9:0]  ONESHOT_LEN_IDX   = 10'h331;
  localparam logic [9:0]  COUNT_VAL_IDX     = 10'h340;

  localparam logic [7:0]  COUNT_START_RST   = 8'h00;
  localparam logic [4:0]  ONE_SHOT_RST      = 5'h00;
  localparam logic [4:0]  ONESHOT_MODE_RST  = 5'h00;
  localparam logic [4:0]  TRIG_SEL_RST      = 5'h00;
  localparam logic [15:0] ONESHOT_LEN_RST   = 16'h0010;

  // Field positions inside the configuration register
  localparam int          CFG_MODE_LSB      = 0;
  localparam int          CFG_TSEL_LSB      = 8;

  localparam logic [DATA_W-1:0] READ_ZERO   = 32'h0000_0000;

endpackage

// File: tsc_top.sv
`timescale 1ns/1ns
module tsc_top
  import tsc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic                    CLK,
  input  wire logic                    RST,
  input  wire logic                    PSEL,
  input  wire logic                    PENABLE,
  input  wire logic                    PWRITE,
  input  wire logic [ADDR_W-1:0]       PADDR,
  input  wire logic [DATA_W-1:0]       PWDATA,
  output logic      [DATA_W-1:0]       PRDATA,
  output logic                         PREADY,
  output logic                         PSLVERR,
  output logic      [NUM_TIMERS-1:0]   RUN_FLAGS,
  output logic      [NUM_A_TIMERS-1:0] ONESHOT_START,
  output logic      [NUM_A_TIMERS-1:0] ONESHOT_BUSY,
  output logic      [NUM_TIMERS*CNT_W-1:0] COUNT_VALUES
);

  if (CNT_W < 2 || CNT_W > 16) begin : g_check
    $error("CNT_W must lie between 2 and 16");
  end

  if (NUM_A_TIMERS > NUM_TIMERS || CFG_TSEL_LSB + NUM_A_TIMERS > DATA_W) begin : g_check_map
    $error("Timer fields do not fit the register word");
  end

  logic [NUM_TIMERS-1:0]   run_q;
  logic [NUM_A_TIMERS-1:0] os_mode_q;
  logic [NUM_A_TIMERS-1:0] trig_sel_q;
  logic [CNT_W-1:0]        os_len_q;
  logic [NUM_A_TIMERS-1:0] os_pulse_q;
  logic [NUM_A_TIMERS-1:0] os_busy_q;
  logic [CNT_W-1:0]        cnt_q [NUM_TIMERS];
  logic [DATA_W-1:0]       rdata_q;
  logic                    err_q;

  logic                    setup;
  logic                    wr_acc;
  logic [9:0]              idx;
  logic                    aligned;
  logic                    hit_run;
  logic                    hit_os;
  logic                    hit_cfg;
  logic                    hit_len;
  logic                    hit_cnt;
  logic                    mapped;
  logic [NUM_A_TIMERS-1:0] trig_acc;
  logic [DATA_W-1:0]       rdata_d;

  assign setup   = PSEL && !PENABLE;
  assign wr_acc  = PSEL && PENABLE && PWRITE && !err_q;
  assign idx     = PADDR[ADDR_W-1:2];
  assign aligned = (PADDR[1:0] == 2'h0);

  always_comb begin
    hit_run = 1'b0;
    hit_os  = 1'b0;
    hit_cfg = 1'b0;
    hit_len = 1'b0;
    hit_cnt = 1'b0;
    if (!aligned) begin
      hit_run = 1'b0;
    end else if (idx == COUNT_START_IDX) begin
      hit_run = 1'b1;
    end else if (idx == ONE_SHOT_IDX) begin
      hit_os = 1'b1;
    end else if (idx == TIMER_CFG_IDX) begin
      hit_cfg = 1'b1;
    end else if (idx == ONESHOT_LEN_IDX) begin
      hit_len = 1'b1;
    end else if (idx >= COUNT_VAL_IDX && idx < COUNT_VAL_IDX + 10'(NUM_TIMERS)) begin
      hit_cnt = 1'b1;
    end
  end

  assign mapped = hit_run || hit_os || hit_cfg || hit_len || hit_cnt;

  // Zero wait states: every access phase completes at its first edge
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && err_q;
  assign PRDATA  = rdata_q;

  always_comb begin
    rdata_d = READ_ZERO;
    if (hit_run) begin
      rdata_d[NUM_TIMERS-1:0] = run_q; // R1
    end else if (hit_os) begin
      rdata_d = READ_ZERO; // R5
    end else if (hit_cfg) begin
      rdata_d[CFG_MODE_LSB +: NUM_A_TIMERS] = os_mode_q;
      rdata_d[CFG_TSEL_LSB +: NUM_A_TIMERS] = trig_sel_q;
    end else if (hit_len) begin
      rdata_d[CNT_W-1:0] = os_len_q;
    end else if (hit_cnt) begin
      rdata_d[CNT_W-1:0] = cnt_q[3'(idx - COUNT_VAL_IDX)];
    end
  end

  // Read data and error status are captured in the setup cycle
  always_ff @(posedge CLK) begin
    if (RST) begin
      rdata_q <= READ_ZERO;
      err_q   <= 1'b0;
    end else if (setup) begin
      rdata_q <= PWRITE ? READ_ZERO : rdata_d;
      err_q   <= !mapped || (PWRITE && hit_cnt);
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      run_q <= COUNT_START_RST; // R3
    end else if (wr_acc && hit_run) begin
      run_q <= PWDATA[NUM_TIMERS-1:0]; // R1 R2
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      os_mode_q  <= ONESHOT_MODE_RST;
      trig_sel_q <= TRIG_SEL_RST;
      os_len_q   <= CNT_W'(ONESHOT_LEN_RST);
    end else if (wr_acc && hit_cfg) begin
      os_mode_q  <= PWDATA[CFG_MODE_LSB +: NUM_A_TIMERS];
      trig_sel_q <= PWDATA[CFG_TSEL_LSB +: NUM_A_TIMERS];
    end else if (wr_acc && hit_len) begin
      os_len_q   <= PWDATA[CNT_W-1:0];
    end
  end

  // A one-shot write is honoured only with mode set, source 0 and the run flag already 1
  assign trig_acc = (wr_acc && hit_os) ?
                    (PWDATA[NUM_A_TIMERS-1:0] & run_q[NUM_A_TIMERS-1:0] & os_mode_q & ~trig_sel_q) : // R4 R7 R8
                    ONE_SHOT_RST;

  always_ff @(posedge CLK) begin
    if (RST) begin
      os_pulse_q <= ONE_SHOT_RST; // R6
    end else begin
      os_pulse_q <= trig_acc; // R4
    end
  end

  for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_timer
    if (i < NUM_A_TIMERS) begin : g_a
      logic os_end;
      assign os_end = os_busy_q[i] && run_q[i] && (cnt_q[i] == os_len_q - CNT_W'(1));

      // A new trigger wins over the end of the previous shot
      always_ff @(posedge CLK) begin
        if (RST) begin
          os_busy_q[i] <= 1'b0;
        end else if (trig_acc[i]) begin
          os_busy_q[i] <= 1'b1; // R4
        end else if (os_end || !os_mode_q[i]) begin
          os_busy_q[i] <= 1'b0;
        end
      end

      always_ff @(posedge CLK) begin
        if (RST) begin
          cnt_q[i] <= '0;
        end else if (trig_acc[i]) begin
          cnt_q[i] <= '0; // R4
        end else if (!run_q[i]) begin
          cnt_q[i] <= cnt_q[i]; // R9
        end else if (os_mode_q[i]) begin
          if (os_busy_q[i] && !os_end) begin
            cnt_q[i] <= cnt_q[i] + CNT_W'(1);
          end
        end else begin
          cnt_q[i] <= cnt_q[i] + CNT_W'(1); // R1
        end
      end

      // Checks for this A timer
      AST_OS_CNT_CLEAR: assert property (@(posedge CLK) disable iff (RST) // R4
        trig_acc[i] |=> (cnt_q[i] == '0) && os_busy_q[i])
        else $error("Triggered counter did not restart from zero");

      AST_OS_STEP: assert property (@(posedge CLK) disable iff (RST) // R4
        (os_busy_q[i] && run_q[i] && os_mode_q[i] && !os_end && !trig_acc[i]) |=>
        (cnt_q[i] == $past(cnt_q[i]) + CNT_W'(1)))
        else $error("Busy one-shot counter did not advance");

      AST_OS_SHOT_END: assert property (@(posedge CLK) disable iff (RST) // R4
        (os_end && !trig_acc[i]) |=> !os_busy_q[i])
        else $error("One-shot did not end at its length");

      AST_OS_IDLE_HOLD: assert property (@(posedge CLK) disable iff (RST) // R4
        (os_mode_q[i] && !os_busy_q[i] && !trig_acc[i]) |=> $stable(cnt_q[i]))
        else $error("Idle one-shot counter moved without a trigger");

      AST_OS_MODE_OFF: assert property (@(posedge CLK) disable iff (RST) // R7
        !os_mode_q[i] |=> !os_busy_q[i])
        else $error("Shot stayed busy outside one-shot mode");

      AST_OS_NO_RUN: assert property (@(posedge CLK) disable iff (RST) // R7
        !run_q[i] |=> !ONESHOT_START[i])
        else $error("One-shot started with its run flag clear");

      AST_OS_BUSY_HOLD: assert property (@(posedge CLK) disable iff (RST) // R9
        (os_busy_q[i] && !run_q[i] && os_mode_q[i]) |=> os_busy_q[i])
        else $error("Stopped shot lost its busy state");

      AST_A_FREEZE: assert property (@(posedge CLK) disable iff (RST) // R9
        !run_q[i] |=> $stable(cnt_q[i]))
        else $error("Stopped A counter did not hold its value");

      AST_A_FREE_RUN: assert property (@(posedge CLK) disable iff (RST) // R1
        (run_q[i] && !os_mode_q[i]) |=>
        (cnt_q[i] == $past(cnt_q[i]) + CNT_W'(1)))
        else $error("Running A counter did not advance");
    end else begin : g_b
      always_ff @(posedge CLK) begin
        if (RST) begin
          cnt_q[i] <= '0;
        end else if (run_q[i]) begin
          cnt_q[i] <= cnt_q[i] + CNT_W'(1); // R1 R2
        end
      end

      AST_B_COUNT: assert property (@(posedge CLK) disable iff (RST) // R1
        run_q[i] |=> (cnt_q[i] == $past(cnt_q[i]) + CNT_W'(1)))
        else $error("Running B counter did not advance");

      AST_B_FREEZE: assert property (@(posedge CLK) disable iff (RST) // R9
        !run_q[i] |=> $stable(cnt_q[i]))
        else $error("Stopped B counter did not hold its value");
    end
    assign COUNT_VALUES[i*CNT_W +: CNT_W] = cnt_q[i];
  end

  assign RUN_FLAGS     = run_q;
  assign ONESHOT_START = os_pulse_q;
  assign ONESHOT_BUSY  = os_busy_q;

  // Checks
  logic [CNT_W-1:0] cnt0_prev_q;
  always_ff @(posedge CLK) begin
    cnt0_prev_q <= cnt_q[0];
  end

  AST_RUN_READ: assert property (@(posedge CLK) disable iff (RST) // R1
    (setup && !PWRITE && hit_run) |=> (PRDATA == {{(DATA_W-NUM_TIMERS){1'b0}}, $past(run_q)}))
    else $error("Run flags did not read back");

  AST_READ_STANDS: assert property (@(posedge CLK) disable iff (RST) // R1
    !setup |=> $stable(PRDATA))
    else $error("Read data changed outside a setup cycle");

  AST_RUN_WRITE: assert property (@(posedge CLK) disable iff (RST) // R1
    (PSEL && PENABLE && PWRITE && hit_run && !err_q) |=> (run_q == $past(PWDATA[NUM_TIMERS-1:0])))
    else $error("Run flags did not take the written value");

  AST_RUN_HOLD: assert property (@(posedge CLK) disable iff (RST) // R2
    !(PSEL && PENABLE && PWRITE && hit_run) |=> $stable(run_q))
    else $error("Run flags changed without a write");

  AST_RUN_RESET: assert property (@(posedge CLK) // R3
    RST |=> (RUN_FLAGS == COUNT_START_RST))
    else $error("Run flags not cleared by reset");

  AST_OS_START: assert property (@(posedge CLK) disable iff (RST) // R4
    (trig_acc != ONE_SHOT_RST) |=> (ONESHOT_START == $past(trig_acc)) && ((ONESHOT_BUSY & ONESHOT_START) == ONESHOT_START))
    else $error("Accepted one-shot did not start");

  AST_OS_READ_ZERO: assert property (@(posedge CLK) disable iff (RST) // R5
    (setup && !PWRITE && hit_os) |=> (PENABLE && PRDATA == READ_ZERO))
    else $error("One-shot register read back nonzero");

  AST_OS_RESET: assert property (@(posedge CLK) // R6
    RST |=> (ONESHOT_START == ONE_SHOT_RST) && (ONESHOT_BUSY == ONE_SHOT_RST))
    else $error("One-shot state not cleared by reset");

  AST_OS_GATED: assert property (@(posedge CLK) disable iff (RST) // R7
    ##1 ((ONESHOT_START & ~($past(run_q[NUM_A_TIMERS-1:0]) & $past(os_mode_q) & ~$past(trig_sel_q))) == ONE_SHOT_RST))
    else $error("One-shot started without its preconditions");

  AST_OS_LOW_BITS: assert property (@(posedge CLK) disable iff (RST) // R8
    (wr_acc && hit_os && PWDATA[NUM_A_TIMERS-1:0] == ONE_SHOT_RST) |=> (ONESHOT_START == ONE_SHOT_RST))
    else $error("Upper one-shot bits started a timer");

  AST_FREEZE: assert property (@(posedge CLK) disable iff (RST) // R9
    (!run_q[0] && !trig_acc[0]) ##1 (!run_q[0] && !trig_acc[0]) |=> (cnt_q[0] == cnt0_prev_q))
    else $error("Stopped counter did not hold its value");

  COV_RUN_SET: cover property (@(posedge CLK) disable iff (RST)
    (wr_acc && hit_run && PWDATA[NUM_TIMERS-1:0] != COUNT_START_RST));

  COV_OS_FIRE: cover property (@(posedge CLK) disable iff (RST)
    (trig_acc != ONE_SHOT_RST) ##1 ONESHOT_BUSY[0] ##[1:40] !ONESHOT_BUSY[0]);

  COV_OS_REFUSED: cover property (@(posedge CLK) disable iff (RST)
    (wr_acc && hit_os && PWDATA[0] && !run_q[0]));

  COV_ERR: cover property (@(posedge CLK) disable iff (RST) PSLVERR);

  COV_CNT_READ: cover property (@(posedge CLK) disable iff (RST)
    (setup && !PWRITE && hit_cnt));

endmodule

// File: tsc_tb.sv
`timescale 1ns/1ns
module tb
  import tsc_pkg::*;
;
  localparam logic [11:0] RUN_A = {COUNT_START_IDX, 2'b00};
  localparam logic [11:0] OS_A  = {ONE_SHOT_IDX, 2'b00};
  logic                 CLK = 1'b0;
  logic                 RST = 1'b1;
  logic                 PSEL = 1'b0;
  logic                 PENABLE = 1'b0;
  logic                 PWRITE = 1'b0;
  logic [ADDR_W-1:0]    PADDR = '0;
  logic [DATA_W-1:0]    PWDATA = '0;
  logic [DATA_W-1:0]    PRDATA;
  logic                 PREADY;
  logic                 PSLVERR;
  logic [7:0]           RUN_FLAGS;
  logic [4:0]           ONESHOT_START;
  logic [4:0]           ONESHOT_BUSY;
  logic [127:0]         COUNT_VALUES;
  logic [31:0]          d;
  logic                 e;
  logic [15:0]          c;
  int                   err_count = 0;
  int                   compares = 0;
  int                   cyc = 0;
  int                   os_cnt [5] = '{0, 0, 0, 0, 0};

  tsc_top dut_u (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
                 .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .RUN_FLAGS(RUN_FLAGS),
                 .ONESHOT_START(ONESHOT_START), .ONESHOT_BUSY(ONESHOT_BUSY), .COUNT_VALUES(COUNT_VALUES));

  always #5 CLK = ~CLK;

  always @(posedge CLK) begin
    for (int i = 0; i < 5; i++) begin
      if (ONESHOT_START[i] === 1'b1) begin
        os_cnt[i] <= os_cnt[i] + 1;
      end
    end
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Entered and left at a rising edge; one idle cycle between transfers
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
    PSEL    <= 1'b1;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    d = PRDATA;
    e = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask

  initial begin
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    apb(RUN_A, 1'b0, '0);
    chk("run_reg", d, 32'h0000_0000);
    apb(OS_A, 1'b0, '0);
    chk("os_reg", d, 32'h0000_0000);
    chk("run_port", {24'h0, RUN_FLAGS}, 32'h0000_0000);
    chk("os_port", {22'h0, ONESHOT_BUSY, ONESHOT_START}, 32'h0000_0000);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      apb(RUN_A, 1'b1, 32'h1 << i);
      apb(RUN_A, 1'b0, '0);
      chk("run_reg", d, 32'h1 << i);
      chk("run_port", {24'h0, RUN_FLAGS}, 32'h1 << i);
    end
    apb(RUN_A, 1'b1, 32'hFFFF_FFA5);
    apb(RUN_A, 1'b0, '0);
    chk("run_reg", d, 32'h0000_00A5);
    $display("test run flags done");
    apb(RUN_A, 1'b1, 32'h0000_0000);
    c = COUNT_VALUES[80 +: 16];
    repeat (5) @(posedge CLK);
    chk("cnt_hold", {16'h0, COUNT_VALUES[80 +: 16]}, {16'h0, c});
    apb(RUN_A, 1'b1, 32'h0000_0020);
    c = COUNT_VALUES[80 +: 16];
    repeat (5) @(posedge CLK);
    chk("cnt_run", {16'h0, COUNT_VALUES[80 +: 16]}, {16'h0, c + 16'h5});
    $display("test counting done");
    // A2 has trigger source 1, A3 has its run flag clear
    apb({TIMER_CFG_IDX, 2'b00}, 1'b1, 32'h0000_041F);
    apb({TIMER_CFG_IDX, 2'b00}, 1'b0, '0);
    chk("cfg_reg", d, 32'h0000_041F);
    apb({ONESHOT_LEN_IDX, 2'b00}, 1'b1, 32'h0000_0004);
    apb(RUN_A, 1'b1, 32'h0000_0017);
    for (int i = 0; i < 5; i++) begin
      apb(OS_A, 1'b1, 32'h1 << i);
      chk("os_busy", {31'h0, ONESHOT_BUSY[i]}, (i == 2 || i == 3) ? 32'h0 : 32'h1);
      @(posedge CLK);
      chk("os_pulses", os_cnt[i], (i == 2 || i == 3) ? 32'h0 : 32'h1);
      apb(OS_A, 1'b0, '0);
      chk("os_read", d, 32'h0000_0000);
    end
    repeat (10) @(posedge CLK);
    chk("os_end", {27'h0, ONESHOT_BUSY}, 32'h0000_0000);
    chk("os_count", {16'h0, COUNT_VALUES[15:0]}, 32'h0000_0003);
    apb({COUNT_VAL_IDX, 2'b00}, 1'b0, '0);
    chk("os_count_reg", d, 32'h0000_0003);
    apb(RUN_A, 1'b1, 32'h0000_001F);
    repeat (2) @(posedge CLK);
    chk("os_late", os_cnt[3], 32'h0000_0000);
    apb(OS_A, 1'b1, 32'hFFFF_FFE0);
    chk("os_high_bits", {27'h0, ONESHOT_BUSY}, 32'h0000_0000);
    apb({ONESHOT_LEN_IDX, 2'b00}, 1'b1, 32'h0000_0040);
    apb(OS_A, 1'b1, 32'h0000_0001);
    chk("os_long", {31'h0, ONESHOT_BUSY[0]}, 32'h0000_0001);
    apb({TIMER_CFG_IDX, 2'b00}, 1'b1, 32'h0000_041E);
    @(posedge CLK);
    chk("os_mode_off", {31'h0, ONESHOT_BUSY[0]}, 32'h0000_0000);
    $display("test one-shot done");
    apb(12'hC84, 1'b0, '0);
    chk("unmapped_err", {31'h0, e}, 32'h0000_0001);
    chk("unmapped_data", d, 32'h0000_0000);
    $display("test unmapped done");
    give_verdict();
  end
endmodule
